// File: bench/peak_i2c_asserts.sv
/*
  concurrent checks at the ports of the two-wire target.
  assumes raw bus levels on scl_in and sda_in, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module peak_i2c_asserts
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic        conv_valid,
  input wire logic [11:0] conv_result,
  input wire logic        auto_mode,
  input wire logic [2:0]  cycle_time,
  input wire logic        high_speed_mode
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // -----------------------------------------------------------------
  // bus conditions
  // -----------------------------------------------------------------
  sequence start_seq;
    scl_in && $fell(sda_in);
  endsequence

  sequence stop_seq;
    scl_in && $rose(sda_in);
  endsequence

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  mode_field_a:
  assert property (auto_mode == (cycle_time != 3'h0))
    else $error("auto mode disagrees with cycle field");
  reset_quiet_a:
  assert property ($rose(rst_n) |-> !sda_oe && !auto_mode &&
                   !high_speed_mode && cycle_time == 3'h0)
    else $error("outputs not idle after reset");
  pull_low_a:
  assert property (sda_out == 1'b0)
    else $error("data driven high");
  drive_scl_low_a:
  assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data drive changed while clock high");
  start_silent_a:
  assert property (start_seq |=> !sda_oe [*8])
    else $error("drive right after start");
  stop_idle_a:
  assert property (stop_seq |=> !sda_oe [*8])
    else $error("drive after stop");
  hs_enter_a:
  assert property ($rose(high_speed_mode) |-> !sda_oe && !$past(sda_oe, 8))
    else $error("master code acknowledged");
  hs_leave_a:
  assert property ($fell(high_speed_mode) |-> scl_in && sda_in)
    else $error("high speed left without stop");
  cfg_commit_a:
  assert property ($changed(cycle_time) |-> !scl_in)
    else $error("config changed while clock high");
endmodule

`default_nettype wire

// File: bench/peak_i2c_master.sv
/*
  behavioural bus master for the two-wire target port.
  assumes an external pull-up on both lines; calls start on a falling
  clk edge, bit slot of 1600 ns, scl still between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module peak_i2c_master
(
  output logic     scl,
  output logic     oe,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    oe  = 1'b0;
  end

  // -----------------------------------------------------------------
  // bit slot: data set in low phase, sampled late in high phase
  // -----------------------------------------------------------------
  task automatic slot(input logic b, output logic s);
    #600 oe = ~b;
    #400 scl = 1'b1;
    #500 s = sda;
    #100 scl = 1'b0;
  endtask

  task automatic start();
    if (!scl)
    begin
      #600 oe = 1'b0;
      #400 scl = 1'b1;
    end
    #500 oe = 1'b1;
    #500 scl = 1'b0;
  endtask

  task automatic stop();
    #600 oe = 1'b1;
    #400 scl = 1'b1;
    #500 oe = 1'b0;
    #500;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(d[i], s);
    slot(1'b1, ack);
  endtask

  task automatic rbyte(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(1'b1, d[i]);
    slot(nack, s);
  endtask
endmodule

`default_nettype wire

// File: bench/test_i2c_pointer_regs_with_peak_hold.sv
/*
  self-checking bench for the two-wire target with peak register.
  assumes the master model in peak_i2c_master and the port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module test_i2c_pointer_regs_with_peak_hold;
  localparam logic [6:0] ADDR = peak_i2c_pkg::TARGET_ADDR_DEF;
  localparam logic [7:0] PK   = peak_i2c_pkg::PTR_PEAK;
  localparam logic [7:0] CF   = peak_i2c_pkg::PTR_CONFIG;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        scl;
  logic        m_oe;
  wire logic   sda;
  logic        sda_out;
  logic        sda_oe;
  logic        conv_valid = 1'b0;
  logic [11:0] conv_result = 12'h000;
  logic        auto_mode;
  logic [2:0]  cycle_time;
  logic        hs;
  int          errors = 0;
  int          comparisons = 0;
  logic [7:0]  byte_q[$];
  logic        ack_q[$];
  logic [7:0]  rx_byte;
  logic        rx_ack;
  event        got_byte;
  event        got_ack;
  logic [11:0] pk;
  logic [11:0] r;
  logic        auto_exp = 1'b0;

  always #50 clk = ~clk;
  assign sda = ~(m_oe | sda_oe);

  peak_i2c_target #(.TARGET_ADDR(ADDR)) dut
  (
    .clk, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out, .sda_oe,
    .conv_valid, .conv_result, .auto_mode, .cycle_time,
    .high_speed_mode(hs)
  );
  peak_i2c_master m (.scl, .oe(m_oe), .sda);

  // -----------------------------------------------------------------
  // comparison and report
  // -----------------------------------------------------------------
  task automatic tally(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_byte(logic [7:0] e, logic [7:0] g);
    tally("read byte", 16'(e), 16'(g));
  endtask
  task automatic check_ack(logic e, logic g);
    tally("ack bit", 16'(e), 16'(g));
  endtask
  task automatic check_flag(string n, logic [2:0] e, logic [2:0] g);
    tally(n, 16'(e), 16'(g));
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  always @(got_byte)
    check_byte(byte_q.size() > 0 ? byte_q.pop_front() : 8'hxx,
               rx_byte);
  always @(got_ack)
    check_ack(ack_q.size() > 0 ? ack_q.pop_front() : 1'bx, rx_ack);

  // -----------------------------------------------------------------
  // transfers
  // -----------------------------------------------------------------
  task automatic send(logic [7:0] b, logic e);
    ack_q.push_back(e);
    m.wbyte(b, rx_ack);
    ->got_ack;
  endtask
  task automatic point(logic [7:0] p);
    m.start();
    send({ADDR, 1'b0}, 1'b0);
    send(p, 1'b0);
  endtask
  task automatic fetch(logic [15:0] w, int n);
    send({ADDR, 1'b1}, 1'b0);
    for (int i = 0; i < 2 * n; i++)
    begin
      byte_q.push_back(i[0] ? w[7:0] : w[15:8]);
      m.rbyte(i == 2 * n - 1, rx_byte);
      ->got_byte;
    end
    m.stop();
  endtask
  task automatic rdreg(logic [7:0] p, logic [15:0] w, int n);
    point(p);
    m.start();
    fetch(w, n);
  endtask
  task automatic wrreg(logic [7:0] p, logic [15:0] w);
    point(p);
    send(w[15:8], 1'b0);
    send(w[7:0], 1'b0);
    m.stop();
  endtask
  task automatic conv(logic [11:0] v);
    conv_result = v;
    conv_valid = 1'b1;
    @(negedge clk);
    conv_valid = 1'b0;
    if (auto_exp && v > pk)
      pk = v;
  endtask

  initial
  begin
    #5_000_000;
    errors++;
    print_verdict();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial
  begin
    void'($urandom(14730));
    pk = 12'h000;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    r = 12'($urandom());
    conv(r);
    m.start();
    fetch({4'h0, r}, 2);
    rdreg(PK, 16'h0000, 1);
    wrreg(CF, 16'h0020);
    auto_exp = 1'b1;
    check_flag("auto_mode", 3'h1, {2'b00, auto_mode});
    check_flag("cycle_time", 3'h1, cycle_time);
    repeat (6)
      conv(12'($urandom()));
    rdreg(PK, {4'h0, pk}, 1);
    m.start();
    fetch({4'h0, pk}, 1);
    wrreg(PK, 16'h0000);
    pk = 12'h000;
    rdreg(PK, 16'h0000, 1);
    wrreg(PK, 16'hf123);
    rdreg(PK, 16'h0123, 1);
    point(PK);
    send(8'h04, 1'b0);
    send(8'h56, 1'b0);
    send(8'h07, 1'b0);
    send(8'h89, 1'b0);
    m.stop();
    pk = 12'h789;
    point(PK);
    send(8'h0a, 1'b0);
    m.stop();
    rdreg(PK, 16'h0789, 1);
    m.start();
    send({ADDR ^ 7'h01, 1'b0}, 1'b1);
    m.stop();
    m.start();
    send(8'h0b, 1'b1);
    m.start();
    check_flag("high_speed_mode", 3'h1, {2'b00, hs});
    fetch(16'h0789, 1);
    check_flag("high_speed_mode", 3'h0, {2'b00, hs});
    wrreg(CF, 16'h0000);
    check_flag("auto_mode", 3'h0, {2'b00, auto_mode});
    auto_exp = 1'b0;
    conv(12'hfff);
    rdreg(PK, 16'h0789, 1);
    #1000;
    print_verdict();
  end
endmodule

bind peak_i2c_target peak_i2c_asserts chk
(
  .clk, .rst_n, .scl_in, .sda_in, .sda_out, .sda_oe, .conv_valid,
  .conv_result, .auto_mode, .cycle_time, .high_speed_mode
);

`default_nettype wire

// File: core/line_filter.sv
/*
  three-stage synchroniser for the clock and data lines.
  assumes both lines idle high; a level is taken once stages two and
  three agree.
*/
`timescale 1ns/1ps
`default_nettype none

module line_filter
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire peak_i2c_pkg::line_type raw,
  output var  peak_i2c_pkg::line_type clean
);

  logic [1:0] raw_v;
  logic [1:0] s1_r;
  logic [1:0] s2_r;
  logic [1:0] s3_r;
  logic [1:0] clean_r;

  assign raw_v = raw;
  assign clean = peak_i2c_pkg::line_type'(clean_r);

  // ---------------------------------------------------------------
  // per-line filter
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_line
    always_ff @(posedge clk)
    begin
      if (!rst_n)
      begin
        s1_r[i]    <= peak_i2c_pkg::LINE_IDLE;
        s2_r[i]    <= peak_i2c_pkg::LINE_IDLE;
        s3_r[i]    <= peak_i2c_pkg::LINE_IDLE;
        clean_r[i] <= peak_i2c_pkg::LINE_IDLE;
      end
      else
      begin
        s1_r[i] <= raw_v[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
        if (s2_r[i] == s3_r[i])
        begin
          clean_r[i] <= s3_r[i];
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: core/peak_hold.sv
/*
  peak-result register: keeps the highest conversion in automatic mode.
  assumes conv_valid is a one-cycle pulse per finished conversion.
*/
`timescale 1ns/1ps
`default_nettype none

module peak_hold
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        auto_mode,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_result,
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_value,
  output logic      [11:0] peak
);

  logic [11:0] peak_r;

  assign peak = peak_r;

  // ---------------------------------------------------------------
  // update
  // ---------------------------------------------------------------
  // a bus write wins over a conversion in the same cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      peak_r <= peak_i2c_pkg::PEAK_RESET;
    end
    else if (wr_en)
    begin
      peak_r <= wr_value;
    end
    else if (auto_mode && conv_valid && (conv_result > peak_r))
    begin
      peak_r <= conv_result;
    end
  end

endmodule

`default_nettype wire

// File: core/peak_i2c_pkg.sv
/*
  shared constants, types and states of the two-wire target port with
  its peak-result register.
  assumes a single system clock; nothing here holds logic.
*/
package peak_i2c_pkg;

  // ---------------------------------------------------------------
  // register pointers and layouts
  // ---------------------------------------------------------------
  localparam logic [7:0]  PTR_CONV        = 8'h00;
  localparam logic [7:0]  PTR_CONFIG      = 8'h02;
  localparam logic [7:0]  PTR_PEAK        = 8'h07;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam int          RES_W           = 12;
  localparam logic [11:0] PEAK_RESET      = 12'h000;
  localparam logic [11:0] CONV_RESET      = 12'h000;
  localparam logic [7:0]  CFG_RESET       = 8'h00;
  localparam logic [7:0]  CFG_WR_MASK     = 8'hfd;
  localparam int          CYCLE_LSB       = 5;
  localparam int          CYCLE_MSB       = 7;
  localparam logic [2:0]  CYCLE_OFF       = 3'h0;
  localparam logic [3:0]  PAD_ZERO        = 4'h0;
  localparam logic [7:0]  BYTE_ZERO       = 8'h00;

  // ---------------------------------------------------------------
  // link constants
  // ---------------------------------------------------------------
  localparam logic [6:0]  TARGET_ADDR_DEF = 7'h54;
  localparam logic [4:0]  MASTER_CODE_TOP = 5'h01;
  localparam logic [3:0]  RX_LAST_BIT     = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT     = 4'h7;
  localparam logic [3:0]  BIT_ZERO        = 4'h0;
  localparam logic [3:0]  BIT_ONE         = 4'h1;
  localparam logic        LINE_IDLE       = 1'b1;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic scl;
    logic sda;
  } line_type;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_ACK = 3'b010,
    ST_TX     = 3'b011,
    ST_TX_ACK = 3'b100,
    ST_WAIT   = 3'b101
  } link_state_type;

  typedef enum logic [1:0] {
    BK_ADDR = 2'b00,
    BK_PTR  = 2'b01,
    BK_HI   = 2'b10,
    BK_LO   = 2'b11
  } byte_kind_type;

endpackage

// File: core/peak_i2c_target.sv
/*
  two-wire target port with 8-bit pointer into 16-bit registers:
  conversion result, configuration and peak result.
  assumes an external pull-up on both lines, a master that drives scl,
  and a converter that pulses conv_valid with each new result.
*/
`timescale 1ns/1ps
`default_nettype none

module peak_i2c_target
#(
  parameter logic [6:0] TARGET_ADDR = peak_i2c_pkg::TARGET_ADDR_DEF
)
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        conv_valid,
  input  wire logic [11:0] conv_result,
  output logic             auto_mode,
  output logic      [2:0]  cycle_time,
  output logic             high_speed_mode
);

  peak_i2c_pkg::line_type       raw_lines;
  peak_i2c_pkg::line_type       lines;
  peak_i2c_pkg::link_state_type state_r;
  peak_i2c_pkg::link_state_type state_nxt;
  peak_i2c_pkg::byte_kind_type  kind_r;

  logic        scl_q_r;
  logic        sda_q_r;
  logic        start_cond;
  logic        stop_cond;
  logic        scl_rise;
  logic        scl_fall;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  rx_shift_r;
  logic [7:0]  tx_shift_r;
  logic        rd_mode_r;
  logic        tx_hi_r;
  logic        drive_low_r;
  logic        hs_r;
  logic [7:0]  ptr_r;
  logic [7:0]  hi_byte_r;
  logic [15:0] rd_word_r;
  logic [7:0]  cfg_r;
  logic [11:0] conv_r;
  logic [11:0] peak;
  logic [15:0] rd_value;
  logic [7:0]  next_tx;
  logic        rx_done;
  logic        addr_match;
  logic        is_master_code;
  logic        addr_ok;
  logic        wr_fire;
  logic        load_tx;
  logic        peak_wr;

  // ---------------------------------------------------------------
  // line sampling and conditions
  // ---------------------------------------------------------------
  assign raw_lines.scl = scl_in;
  assign raw_lines.sda = sda_in;

  line_filter u_filter
  (
    .clk   (clk),
    .rst_n (rst_n),
    .raw   (raw_lines),
    .clean (lines)
  );

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q_r <= peak_i2c_pkg::LINE_IDLE;
      sda_q_r <= peak_i2c_pkg::LINE_IDLE;
    end
    else
    begin
      scl_q_r <= lines.scl;
      sda_q_r <= lines.sda;
    end
  end

  // edges are taken from the filtered lines; a level held under two clk cycles is dropped
  assign start_cond = lines.scl & scl_q_r & sda_q_r & ~lines.sda;
  assign stop_cond  = lines.scl & scl_q_r & ~sda_q_r & lines.sda;
  assign scl_rise   = lines.scl & ~scl_q_r;
  assign scl_fall   = ~lines.scl & scl_q_r;

  // ---------------------------------------------------------------
  // byte decode
  // ---------------------------------------------------------------
  assign rx_done = (state_r == peak_i2c_pkg::ST_RX) && scl_fall
                   && (bit_cnt_r == peak_i2c_pkg::RX_LAST_BIT);
  assign addr_match     = (rx_shift_r[7:1] == TARGET_ADDR);
  assign is_master_code = (rx_shift_r[7:3] == peak_i2c_pkg::MASTER_CODE_TOP);
  assign addr_ok        = addr_match && !is_master_code;
  assign wr_fire = rx_done && (kind_r == peak_i2c_pkg::BK_LO);
  assign load_tx = scl_fall
                   && (((state_r == peak_i2c_pkg::ST_RX_ACK) && rd_mode_r)
                   || (state_r == peak_i2c_pkg::ST_TX_ACK));

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb
  begin
    case (ptr_r)
      peak_i2c_pkg::PTR_CONV:
        rd_value = {peak_i2c_pkg::PAD_ZERO, conv_r};
      peak_i2c_pkg::PTR_CONFIG:
        rd_value = {peak_i2c_pkg::BYTE_ZERO, cfg_r};
      peak_i2c_pkg::PTR_PEAK:
        rd_value = {peak_i2c_pkg::PAD_ZERO, peak};
      default:
        rd_value = {peak_i2c_pkg::BYTE_ZERO, peak_i2c_pkg::BYTE_ZERO};
    endcase
  end

  // upper byte comes live, lower byte from the word caught with it
  assign next_tx = tx_hi_r ? rd_value[15:8] : rd_word_r[7:0];

  // ---------------------------------------------------------------
  // protocol state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      peak_i2c_pkg::ST_IDLE:
        state_nxt = state_r;
      peak_i2c_pkg::ST_WAIT:
        state_nxt = state_r;
      peak_i2c_pkg::ST_RX:
        if (rx_done && (kind_r == peak_i2c_pkg::BK_ADDR))
          state_nxt = addr_ok ? peak_i2c_pkg::ST_RX_ACK
                              : peak_i2c_pkg::ST_WAIT;
        else if (rx_done)
          state_nxt = peak_i2c_pkg::ST_RX_ACK;
      peak_i2c_pkg::ST_RX_ACK:
        if (scl_fall)
          state_nxt = rd_mode_r ? peak_i2c_pkg::ST_TX
                                : peak_i2c_pkg::ST_RX;
      peak_i2c_pkg::ST_TX:
        if (scl_fall && (bit_cnt_r == peak_i2c_pkg::TX_LAST_BIT))
          state_nxt = peak_i2c_pkg::ST_TX_ACK;
      peak_i2c_pkg::ST_TX_ACK:
        if (scl_rise && lines.sda)
          state_nxt = peak_i2c_pkg::ST_WAIT;
        else if (scl_fall)
          state_nxt = peak_i2c_pkg::ST_TX;
      default:
        state_nxt = peak_i2c_pkg::ST_IDLE;
    endcase
    if (stop_cond)
      state_nxt = peak_i2c_pkg::ST_IDLE;
    else if (start_cond)
      state_nxt = peak_i2c_pkg::ST_RX;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_r <= peak_i2c_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // ---------------------------------------------------------------
  // bit counter and byte kind
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      bit_cnt_r <= peak_i2c_pkg::BIT_ZERO;
    else if (start_cond || (state_nxt != state_r))
      bit_cnt_r <= peak_i2c_pkg::BIT_ZERO;
    else if ((state_r == peak_i2c_pkg::ST_RX) && scl_rise)
      bit_cnt_r <= bit_cnt_r + peak_i2c_pkg::BIT_ONE;
    else if ((state_r == peak_i2c_pkg::ST_TX) && scl_fall)
      bit_cnt_r <= bit_cnt_r + peak_i2c_pkg::BIT_ONE;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      kind_r    <= peak_i2c_pkg::BK_ADDR;
      rd_mode_r <= 1'b0;
    end
    else if (start_cond)
    begin
      kind_r    <= peak_i2c_pkg::BK_ADDR;
      rd_mode_r <= 1'b0;
    end
    else if (rx_done)
    begin
      case (kind_r)
        peak_i2c_pkg::BK_ADDR:
        begin
          kind_r    <= peak_i2c_pkg::BK_PTR;
          rd_mode_r <= rx_shift_r[0];
        end
        peak_i2c_pkg::BK_PTR:
          kind_r <= peak_i2c_pkg::BK_HI;
        peak_i2c_pkg::BK_HI:
          kind_r <= peak_i2c_pkg::BK_LO;
        peak_i2c_pkg::BK_LO:
          kind_r <= peak_i2c_pkg::BK_HI;
        default:
          kind_r <= peak_i2c_pkg::BK_ADDR;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // receive shifter
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rx_shift_r <= peak_i2c_pkg::BYTE_ZERO;
    else if ((state_r == peak_i2c_pkg::ST_RX) && scl_rise)
      rx_shift_r <= {rx_shift_r[6:0], lines.sda};
  end

  // ---------------------------------------------------------------
  // transmit and data line drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      tx_shift_r  <= peak_i2c_pkg::BYTE_ZERO;
      tx_hi_r     <= 1'b1;
      rd_word_r   <= {peak_i2c_pkg::BYTE_ZERO, peak_i2c_pkg::BYTE_ZERO};
      drive_low_r <= 1'b0;
    end
    else if (start_cond || stop_cond)
    begin
      tx_hi_r     <= 1'b1;
      drive_low_r <= 1'b0;
    end
    // ack every accepted byte; master code and foreign address get none
    else if (rx_done)
      drive_low_r <= (kind_r != peak_i2c_pkg::BK_ADDR) || addr_ok;
    else if (load_tx && (state_nxt == peak_i2c_pkg::ST_TX))
    begin
      tx_shift_r  <= next_tx;
      tx_hi_r     <= ~tx_hi_r;
      drive_low_r <= ~next_tx[7];
      if (tx_hi_r)
        rd_word_r <= rd_value;
    end
    else if ((state_r == peak_i2c_pkg::ST_TX) && scl_fall)
    begin
      if (bit_cnt_r == peak_i2c_pkg::TX_LAST_BIT)
        drive_low_r <= 1'b0;
      else
      begin
        tx_shift_r  <= {tx_shift_r[6:0], 1'b0};
        drive_low_r <= ~tx_shift_r[6];
      end
    end
    else if (scl_fall && (state_r == peak_i2c_pkg::ST_RX_ACK))
      drive_low_r <= 1'b0;
    else if ((state_r == peak_i2c_pkg::ST_WAIT)
             || (state_r == peak_i2c_pkg::ST_IDLE))
      drive_low_r <= 1'b0;
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drive_low_r;

  // ---------------------------------------------------------------
  // speed mode
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      hs_r <= 1'b0;
    else if (stop_cond)
      hs_r <= 1'b0;
    else if (rx_done && (kind_r == peak_i2c_pkg::BK_ADDR) && is_master_code)
      hs_r <= 1'b1;
  end

  assign high_speed_mode = hs_r;

  // ---------------------------------------------------------------
  // pointer and register writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ptr_r     <= peak_i2c_pkg::PTR_RESET;
      hi_byte_r <= peak_i2c_pkg::BYTE_ZERO;
      cfg_r     <= peak_i2c_pkg::CFG_RESET;
    end
    else if (rx_done)
    begin
      if (kind_r == peak_i2c_pkg::BK_PTR)
        ptr_r <= rx_shift_r;
      if (kind_r == peak_i2c_pkg::BK_HI)
        hi_byte_r <= rx_shift_r;
      if (wr_fire && (ptr_r == peak_i2c_pkg::PTR_CONFIG))
        cfg_r <= rx_shift_r & peak_i2c_pkg::CFG_WR_MASK;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      conv_r <= peak_i2c_pkg::CONV_RESET;
    else if (conv_valid)
      conv_r <= conv_result;
  end

  assign peak_wr    = wr_fire && (ptr_r == peak_i2c_pkg::PTR_PEAK);
  assign cycle_time = cfg_r[peak_i2c_pkg::CYCLE_MSB:peak_i2c_pkg::CYCLE_LSB];
  assign auto_mode  = (cycle_time != peak_i2c_pkg::CYCLE_OFF);

  peak_hold u_peak
  (
    .clk         (clk),
    .rst_n       (rst_n),
    .auto_mode   (auto_mode),
    .conv_valid  (conv_valid),
    .conv_result (conv_result),
    .wr_en       (peak_wr),
    .wr_value    ({hi_byte_r[3:0], rx_shift_r}),
    .peak        (peak)
  );

endmodule

`default_nettype wire
